// ==== src/dynamic_channel_change_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - after registration, moving a 3.1 modem to another domain issues a change request
// - old and new upstream identifiers must differ for older modems in named cases
// - with reinitialize, no response is awaited on the new channel
// - a departure response never frees old-channel resources
// - new-channel resources are usable without an arrival response
// - old resources held until hold time after last request, or modem seen
// - new resources held until reservation time after last request or departure response, unless modem seen
// - reinitialize reserves nothing and runs no reservation timer
// - modem reinitializing mid-change may free new resources early
// - broadcast ranging: late modem on deleted identifier gets a ranging abort
// - reservation time is computed and capped by local policy
// - downstream change of bonded 3.0 modem, or its assigned upstream, uses reinitialize
// - older modem upstream change without transmit config may use nonzero technique
// - re-ranging chosen on path diversity or changed rate, modulation or minislot
// - reservation time kept between four and thirty-five seconds
// - missing jump time is taken as 1.3 seconds
module dynamic_channel_change_ctrl
  import chan_change_pkg::*;
#(
  parameter int TB_DIV = TB_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // move command from policy
  input  wire logic        move_start,
  input  wire logic [1:0]  modem_class,
  input  wire logic        multi_rx,
  input  wire logic        tx_cfg_assigned,
  input  wire logic        ds_change,
  input  wire logic        us_change,
  input  wire logic        path_diverse,
  input  wire logic        phy_param_change,
  input  wire logic [2:0]  tech_pref,
  input  wire logic [7:0]  old_ucid,
  input  wire logic [7:0]  new_ucid_req,
  input  wire logic [15:0] hold_ms,
  input  wire logic [15:0] rng_ms,
  // modem events
  input  wire logic        rsp_depart,
  input  wire logic        rsp_has_jump,
  input  wire logic [15:0] rsp_jump_ms,
  input  wire logic        rsp_arrive,
  input  wire logic        modem_seen_new,
  input  wire logic        modem_reinit_seen,
  input  wire logic        late_use_deleted_sid,
  // request and outcome
  output logic             req_send,
  output logic [2:0]       req_tech,
  output logic [7:0]       new_ucid,
  output logic             old_res_held,
  output logic             new_res_held,
  output logic             new_res_usable,
  output logic             await_arrive_rsp,
  output logic             rng_abort
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] clamp_resv(input logic [16:0] ms);
    if (ms < 17'(RESV_MIN_MS))      clamp_resv = 16'(RESV_MIN_MS);
    else if (ms > 17'(RESV_MAX_MS)) clamp_resv = 16'(RESV_MAX_MS);
    else                            clamp_resv = ms[15:0];
  endfunction

  // refuse a timebase divider that cannot produce a tick
  if (TB_DIV < 1) begin : g_bad_div
    $error("TB_DIV must be at least 1");
  end

  // ---------------------------------------------------------------
  // technique selection
  // ---------------------------------------------------------------
  logic [2:0] next_tech;
  logic       must_reinit;
  always_comb begin
    must_reinit = (modem_class == CLASS_V31)
                || (modem_class == CLASS_V30 && multi_rx && ds_change)
                || (modem_class == CLASS_V30 && tx_cfg_assigned && us_change);
    if (must_reinit)
      next_tech = TECH_REINIT;
    else if ((path_diverse || phy_param_change) && tech_pref > TECH_UCAST_RNG)
      next_tech = TECH_UCAST_RNG;
    else
      next_tech = tech_pref;
  end

  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  logic [31:0] tb_cnt;
  logic        tick;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tb_cnt <= 32'h0;
      tick   <= 1'b0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (tb_cnt >= 32'(TB_DIV - 1)) begin
        tb_cnt <= 32'h0;
        tick   <= 1'b1;
      end else begin
        tb_cnt <= tb_cnt + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // request issue
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_send <= 1'b0;
      req_tech <= TECH_REINIT;
      new_ucid <= 8'h0;
    end else if (clk_en) begin
      req_send <= move_start;
      if (move_start) begin
        req_tech <= next_tech;
        if (modem_class != CLASS_V31 && new_ucid_req == old_ucid &&
            (!ds_change || !us_change || next_tech != TECH_REINIT))
          new_ucid <= old_ucid + 8'h1;
        else
          new_ucid <= new_ucid_req;
      end
    end
  end

  // ---------------------------------------------------------------
  // old-channel hold
  // ---------------------------------------------------------------
  logic [15:0] old_cnt;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      old_cnt      <= 16'h0;
      old_res_held <= 1'b0;
    end else if (clk_en) begin
      if (move_start) begin
        old_cnt      <= (hold_ms == 16'h0) ? 16'(HOLD_DFLT_MS) : hold_ms;
        old_res_held <= 1'b1;
      end else if (modem_seen_new) begin
        old_res_held <= 1'b0;
        old_cnt      <= 16'h0;
      end else if (old_res_held && tick) begin
        // departure response deliberately ignored here
        if (old_cnt <= 16'h1) old_res_held <= 1'b0;
        old_cnt <= (old_cnt == 16'h0) ? 16'h0 : old_cnt - 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // new-channel reservation
  // ---------------------------------------------------------------
  logic [15:0] jump_ms;
  logic [15:0] rxrng_ms;
  logic [15:0] resv_cnt;
  logic        expired;
  always_comb begin
    jump_ms  = rsp_has_jump ? rsp_jump_ms : 16'(JUMP_DFLT_MS);
    rxrng_ms = (next_tech == TECH_BCAST_RNG) ? 16'(BCAST_RNG_MS) : rng_ms;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resv_cnt       <= 16'h0;
      new_res_held   <= 1'b0;
      new_res_usable <= 1'b0;
      expired        <= 1'b0;
    end else if (clk_en) begin
      if (move_start) begin
        expired <= 1'b0;
        if (next_tech == TECH_REINIT) begin
          new_res_held   <= 1'b0;
          new_res_usable <= 1'b0;
          resv_cnt       <= 16'h0;
        end else begin
          new_res_held   <= 1'b1;
          new_res_usable <= 1'b1;
          resv_cnt       <= clamp_resv(17'(JUMP_DFLT_MS) + 17'(rxrng_ms));
        end
      end else if (new_res_held && rsp_depart && req_tech != TECH_REINIT) begin
        resv_cnt <= clamp_resv({1'b0, jump_ms} + 17'(rng_ms_sel(req_tech)));
      end else if (new_res_held && modem_seen_new) begin
        resv_cnt <= 16'h0;
      end else if (new_res_held && modem_reinit_seen) begin
        new_res_held   <= 1'b0;
        new_res_usable <= 1'b0;
      end else if (new_res_held && tick && resv_cnt != 16'h0) begin
        resv_cnt <= resv_cnt - 16'h1;
        if (resv_cnt == 16'h1) begin
          new_res_held   <= 1'b0;
          new_res_usable <= 1'b0;
          expired        <= 1'b1;
        end
      end
    end
  end

  function automatic logic [15:0] rng_ms_sel(input logic [2:0] t);
    rng_ms_sel = (t == TECH_BCAST_RNG) ? 16'(BCAST_RNG_MS) : rng_ms;
  endfunction

  // ---------------------------------------------------------------
  // arrival wait and abort
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      await_arrive_rsp <= 1'b0;
      rng_abort        <= 1'b0;
    end else if (clk_en) begin
      if (move_start)
        await_arrive_rsp <= (next_tech != TECH_REINIT);
      else if (rsp_arrive)
        await_arrive_rsp <= 1'b0;
      rng_abort <= expired && req_tech == TECH_BCAST_RNG
                   && late_use_deleted_sid;
    end
  end

endmodule

// ==== src/chan_change_pkg.sv ====
package chan_change_pkg;

  // ---------------------------------------------------------------
  // initialization techniques
  // ---------------------------------------------------------------
  localparam logic [2:0] TECH_REINIT     = 3'h0;
  localparam logic [2:0] TECH_BCAST_RNG  = 3'h1;
  localparam logic [2:0] TECH_UCAST_RNG  = 3'h2;
  localparam logic [2:0] TECH_STATION    = 3'h3;
  localparam logic [2:0] TECH_DIRECT     = 3'h4;

  // ---------------------------------------------------------------
  // modem classes
  // ---------------------------------------------------------------
  localparam logic [1:0] CLASS_PRE30     = 2'h0;
  localparam logic [1:0] CLASS_V30       = 2'h1;
  localparam logic [1:0] CLASS_V31       = 2'h2;

  // ---------------------------------------------------------------
  // timing in milliseconds, clock in hertz, tick length in cycles
  // ---------------------------------------------------------------
  localparam int RESV_MIN_MS   = 4000;
  localparam int RESV_MAX_MS   = 35000;
  localparam int JUMP_DFLT_MS  = 1300;
  localparam int BCAST_RNG_MS  = 30000;
  localparam int HOLD_DFLT_MS  = 1000;
  localparam int TB_PERIOD_MS  = 1;
  localparam int CLK_HZ        = 20000000;
  localparam int TB_CYCLES     = CLK_HZ / 1000 * TB_PERIOD_MS;

endpackage

// ==== test/chan_change_asserts.sv ====
`timescale 1ns/1ps
// -----------------------------
// request and resource checks
// -----------------------------
module chan_change_asserts
  import chan_change_pkg::*;
#(
  parameter int TB_DIV = 2
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  // move command and modem events
  input wire logic       move_start,
  input wire logic [1:0] modem_class,
  input wire logic       multi_rx,
  input wire logic       ds_change,
  input wire logic [7:0] old_ucid,
  input wire logic       modem_seen_new,
  input wire logic       late_use_deleted_sid,
  // request and outcome
  input wire logic       req_send,
  input wire logic [2:0] req_tech,
  input wire logic [7:0] new_ucid,
  input wire logic       old_res_held,
  input wire logic       new_res_held,
  input wire logic       new_res_usable,
  input wire logic       await_arrive_rsp,
  input wire logic       rng_abort
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a move taken, and a request with a non-reinit technique
  sequence s_move;
    move_start && clk_en;
  endsequence
  sequence s_req_nz;
    req_send && req_tech != TECH_REINIT;
  endsequence
  AST_REQ_SENT: assert property (s_move |=> req_send)
    else $error("no request after move");
  AST_V31_TECH: assert property (s_move ##0 (modem_class == CLASS_V31) |=> req_tech == 3'h0)
    else $error("3.1 modem given nonzero technique");
  AST_BOND_TECH: assert property (s_move ##0 (modem_class == CLASS_V30 && multi_rx && ds_change)
    |=> req_tech == TECH_REINIT)
    else $error("bonded modem given nonzero technique");
  AST_UCID_DIFF: assert property (s_req_nz |-> new_ucid != $past(old_ucid))
    else $error("upstream ids equal");
  AST_REINIT_NORES: assert property (req_send && req_tech == TECH_REINIT
    |-> !new_res_held && !await_arrive_rsp)
    else $error("reinit reserves or waits");
  AST_USABLE: assert property (s_req_nz |-> new_res_usable && old_res_held)
    else $error("resources not usable at once");
  AST_ABORT_CAUSE: assert property (rng_abort |-> $past(late_use_deleted_sid)
    && $past(req_tech) == TECH_BCAST_RNG && !$past(new_res_held))
    else $error("abort without cause");
  AST_ABORT_SENT: assert property (late_use_deleted_sid && clk_en && !move_start
    && req_tech == TECH_BCAST_RNG && !new_res_held |=> rng_abort)
    else $error("late modem not aborted");
  AST_SEEN_FREE: assert property (modem_seen_new && clk_en && !move_start
    |-> ##[1:2] !old_res_held)
    else $error("old resources kept after modem seen");
endmodule

// ==== test/modem_model.sv ====
`timescale 1ns/1ps
// -----------------------------
// modem side responder
// -----------------------------
module modem_model
  import chan_change_pkg::*;
(
  // clock and request
  input  wire logic        clk_sys,
  input  wire logic        req_send,
  input  wire logic [2:0]  req_tech,
  input  wire logic [1:0]  modem_class,
  // 0 silent, 1 depart only, 2 depart then arrive, 3 depart with jump time
  input  wire logic [1:0]  mode,
  // modem events
  output logic             rsp_depart,
  output logic             rsp_has_jump,
  output logic [15:0]      rsp_jump_ms,
  output logic             rsp_arrive,
  output logic             modem_seen_new,
  // refusal of a request
  output logic             rsp_reject
);
  logic [3:0] cnt = 4'h0;
  logic       refuse;
  initial {rsp_depart, rsp_has_jump, rsp_arrive, modem_seen_new, rsp_reject, rsp_jump_ms} = '0;
  // a 3.1 modem turns down any technique but reinitialize
  assign refuse = req_send && modem_class == CLASS_V31 && req_tech != TECH_REINIT;
  // answers two cycles after a request, well inside the old hold time
  always @(negedge clk_sys) begin
    rsp_reject     <= refuse;
    rsp_depart     <= (cnt == 4'h2);
    rsp_has_jump   <= (cnt == 4'h2) && (mode == 2'h3);
    rsp_jump_ms    <= (cnt == 4'h2 && mode == 2'h3) ? 16'h0064 : ~rsp_jump_ms;
    rsp_arrive     <= (cnt == 4'h1) && (mode == 2'h2);
    modem_seen_new <= (cnt == 4'h1) && (mode == 2'h2);
    if (req_send && mode != 2'h0 && !refuse) cnt <= 4'h3;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) num_checks++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", n, e, a); end
// -----------------------------
// bench top
// -----------------------------
module tb;
  import chan_change_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, move_start = 0, multi_rx = 0, ds_change = 0;
  logic        path_diverse = 0, phy_param_change = 0, late_use_deleted_sid = 0;
  logic [1:0]  modem_class = 0, mode = 0;
  logic [2:0]  tech_pref = 0, req_tech;
  logic [7:0]  old_ucid = 0, new_ucid_req = 0, new_ucid;
  logic [15:0] hold_ms = 16'h0005, rng_ms = 16'h0BB8, rsp_jump_ms;
  logic        req_send, old_res_held, new_res_held, new_res_usable, await_arrive_rsp;
  logic        rng_abort, rsp_depart, rsp_has_jump, rsp_arrive, modem_seen_new;
  logic        tx_cfg_assigned = 0, us_change = 0, modem_reinit_seen = 0, rsp_reject;
  int          error_cnt = 0, num_checks = 0, cycles = 0;
  dynamic_channel_change_ctrl #(.TB_DIV(2)) dynamic_channel_change_ctrl_i (.clk_sys, .sys_rst,
    .clk_en(1'b1), .move_start, .modem_class, .multi_rx, .tx_cfg_assigned, .ds_change,
    .us_change, .path_diverse, .phy_param_change, .tech_pref, .old_ucid, .new_ucid_req,
    .hold_ms, .rng_ms, .rsp_depart, .rsp_has_jump, .rsp_jump_ms, .rsp_arrive, .modem_seen_new,
    .modem_reinit_seen, .late_use_deleted_sid, .req_send, .req_tech, .new_ucid,
    .old_res_held, .new_res_held, .new_res_usable, .await_arrive_rsp, .rng_abort);
  modem_model modem_model_i (.clk_sys, .req_send, .req_tech, .modem_class, .mode, .rsp_depart,
    .rsp_has_jump, .rsp_jump_ms, .rsp_arrive, .modem_seen_new, .rsp_reject);
  always #25 clk_sys = ~clk_sys;
  // hang guard: the scenarios need about 71000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one move request, checked one cycle later
  task automatic move(input logic [1:0] cls, input logic [2:0] tech, input logic [1:0] md);
    @(negedge clk_sys);
    {modem_class, tech_pref, mode, move_start} = {cls, tech, md, 1'b1};
    @(negedge clk_sys);
    move_start = 1'b0;
    `CHK("req_send", 1'b1, req_send)
  endtask
  task automatic t_forced;
    move(CLASS_V31, TECH_UCAST_RNG, 2'h0);
    `CHK("v31 tech", TECH_REINIT, req_tech)
    `CHK("v31 resv", 1'b0, new_res_held)
    `CHK("v31 await", 1'b0, await_arrive_rsp)
    wait_cyc(1);
    `CHK("v31 refused", 1'b0, rsp_reject)
    {multi_rx, ds_change} = 2'b11;
    move(CLASS_V30, TECH_STATION, 2'h0);
    `CHK("v30 tech", TECH_REINIT, req_tech)
    {ds_change, tx_cfg_assigned, us_change} = 3'b011;
    move(CLASS_V30, TECH_STATION, 2'h0);
    `CHK("v30 tx tech", TECH_REINIT, req_tech)
    {multi_rx, tx_cfg_assigned, us_change, path_diverse} = 4'b0001;
    move(CLASS_PRE30, TECH_DIRECT, 2'h0);
    `CHK("diverse tech", TECH_UCAST_RNG, req_tech)
    {path_diverse, phy_param_change} = 2'b01;
    move(CLASS_PRE30, TECH_DIRECT, 2'h0);
    `CHK("phy tech", TECH_UCAST_RNG, req_tech)
    phy_param_change = 1'b0;
  endtask
  task automatic t_hold;
    {old_ucid, new_ucid_req} = 16'h1010;
    move(CLASS_PRE30, TECH_UCAST_RNG, 2'h1);
    `CHK("new ucid", 8'h11, new_ucid)
    `CHK("usable", 1'b1, new_res_usable)
    wait_cyc(5);
    move(CLASS_PRE30, TECH_UCAST_RNG, 2'h1);
    wait_cyc(7);
    `CHK("old kept", 1'b1, old_res_held)
    wait_cyc(6);
    `CHK("old freed", 1'b0, old_res_held)
  endtask
  task automatic t_seen;
    move(CLASS_PRE30, TECH_STATION, 2'h2);
    wait_cyc(5);
    `CHK("old after seen", 1'b0, old_res_held)
    `CHK("new after seen", 1'b1, new_res_held)
    modem_reinit_seen = 1'b1;
    @(negedge clk_sys);
    modem_reinit_seen = 1'b0;
    `CHK("new after reinit", 1'b0, new_res_held)
    `CHK("usable after reinit", 1'b0, new_res_usable)
  endtask
  // reported jump time of 100 ms plus 3000 ms ranging is raised to the floor
  task automatic t_jump;
    move(CLASS_PRE30, TECH_UCAST_RNG, 2'h3);
    wait_cyc(7992);
    `CHK("resv floor", 1'b1, new_res_held)
    wait_cyc(20);
    `CHK("resv jump", 1'b0, new_res_held)
  endtask
  // broadcast ranging reserves 1300 ms default jump plus 30000 ms ranging
  task automatic t_resv;
    move(CLASS_PRE30, TECH_BCAST_RNG, 2'h1);
    wait_cyc(62592);
    `CHK("resv kept", 1'b1, new_res_held)
    wait_cyc(20);
    `CHK("resv freed", 1'b0, new_res_held)
    late_use_deleted_sid = 1'b1;
    @(negedge clk_sys);
    late_use_deleted_sid = 1'b0;
    `CHK("abort", 1'b1, rng_abort)
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    wait_cyc(20);
    sys_rst = 1'b0;
    t_hold();
    t_forced();
    t_seen();
    t_jump();
    t_resv();
    stop_test();
  end
endmodule
bind dynamic_channel_change_ctrl chan_change_asserts #(.TB_DIV(TB_DIV)) chan_change_asserts_i (
  .clk_sys, .sys_rst, .clk_en, .move_start, .modem_class, .multi_rx, .ds_change, .old_ucid,
  .modem_seen_new, .late_use_deleted_sid, .req_send, .req_tech, .new_ucid, .old_res_held,
  .new_res_held, .new_res_usable, .await_arrive_rsp, .rng_abort);
